// >>> include/gsi_pkg.sv
// Package of constants and types for the serial-interface interrupt and status bank
package gsi_pkg;

	// ------------------------------------------------------------
	// Bus widths and answers
	// ------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [15:0] IDX_IRQ_ENABLE = 16'hA001;
	localparam logic [15:0] IDX_IRQ_LATCHED = 16'hA002;
	localparam logic [15:0] IDX_RESOLVED = 16'hA003;
	localparam logic [19:0] ADDR_IRQ_ENABLE = {2'h0, IDX_IRQ_ENABLE, 2'h0};
	localparam logic [19:0] ADDR_IRQ_LATCHED = {2'h0, IDX_IRQ_LATCHED, 2'h0};
	localparam logic [19:0] ADDR_RESOLVED = {2'h0, IDX_RESOLVED, 2'h0};

	// ------------------------------------------------------------
	// Event field positions (enable and latched registers)
	// ------------------------------------------------------------
	localparam int EVT_LSB = 7;
	localparam int EVT_CNT = 8;
	localparam int BIT_SPEED_CHG = 14;
	localparam int BIT_DUPLEX_CHG = 13;
	localparam int BIT_PAGE_RCVD = 12;
	localparam int BIT_AN_DONE = 11;
	localparam int BIT_LINK_DOWN = 10;
	localparam int BIT_LINK_UP = 9;
	localparam int BIT_SYMBOL_ERR = 8;
	localparam int BIT_FALSE_CARRIER = 7;

	// ------------------------------------------------------------
	// Resolved status field positions
	// ------------------------------------------------------------
	localparam int STS_SPEED_MSB = 15;
	localparam int STS_SPEED_LSB = 14;
	localparam int STS_DUPLEX = 13;
	localparam int STS_PAGE = 12;
	localparam int STS_RESOLVED = 11;
	localparam int STS_LINK = 10;
	localparam int STS_SYNC = 5;
	localparam int STS_NO_ENERGY = 4;
	localparam int STS_TX_PAUSE = 3;
	localparam int STS_RX_PAUSE = 2;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [15:0] RST_IRQ_ENABLE = 16'h0000;
	localparam logic [EVT_CNT-1:0] RST_LATCHED = 8'h00;
	localparam logic RST_NO_ENERGY = 1'h1;
	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	// Live state handed in by the serial PCS and negotiation engine
	typedef struct packed {
		logic linkUp;
		logic syncOk;
		logic noEnergy;
		logic anEnabled;
		logic anDone;
		logic pageRcvd;
		logic symbolErr;
		logic falseCarrier;
		logic [1:0] speed;
		logic fullDuplex;
		logic txPause;
		logic rxPause;
	} gsi_pcs_t;

	// Read answer
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [1:0] resp;
	} gsi_rd_t;

endpackage

// >>> verilog/gsi_change_detect.sv
// Samples live PCS state and turns changes into event strobes
`timescale 1ns/10ps
`default_nettype none
module gsi_change_detect (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic swReset,
	input gsi_pkg::gsi_pcs_t pcsIn,
	output gsi_pkg::gsi_pcs_t pcsNow,
	output logic [gsi_pkg::EVT_CNT-1:0] evtSet
);
	import gsi_pkg::*;

	gsi_pcs_t pcsPrev;
	gsi_pcs_t pcsIdle;

	always_comb begin
		pcsIdle = '0;
		pcsIdle.noEnergy = RST_NO_ENERGY;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pcsNow <= '{noEnergy: RST_NO_ENERGY, default: 1'b0};
			pcsPrev <= '{noEnergy: RST_NO_ENERGY, default: 1'b0};
		end else if (swReset) begin
			pcsNow <= pcsIdle;
			pcsPrev <= pcsIdle;
		end else begin
			pcsNow <= pcsIn;
			pcsPrev <= pcsNow;
		end
	end

	always_comb begin
		evtSet = '0;
		evtSet[BIT_SPEED_CHG-EVT_LSB] = pcsNow.speed != pcsPrev.speed;
		evtSet[BIT_DUPLEX_CHG-EVT_LSB] = pcsNow.fullDuplex != pcsPrev.fullDuplex;
		evtSet[BIT_PAGE_RCVD-EVT_LSB] = pcsNow.pageRcvd;
		evtSet[BIT_AN_DONE-EVT_LSB] = pcsNow.anDone & ~pcsPrev.anDone;
		evtSet[BIT_LINK_DOWN-EVT_LSB] = pcsPrev.linkUp & ~pcsNow.linkUp;
		evtSet[BIT_LINK_UP-EVT_LSB] = ~pcsPrev.linkUp & pcsNow.linkUp;
		evtSet[BIT_SYMBOL_ERR-EVT_LSB] = pcsNow.symbolErr;
		evtSet[BIT_FALSE_CARRIER-EVT_LSB] = pcsNow.falseCarrier;
	end
endmodule
`default_nettype wire

// >>> verilog/gsi_flag_bank.sv
// Bank of latched-high event flags, cleared by reading
`timescale 1ns/10ps
`default_nettype none
module gsi_flag_bank (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic swReset,
	input wire logic readClear,
	input wire logic [gsi_pkg::EVT_CNT-1:0] evtSet,
	output logic [gsi_pkg::EVT_CNT-1:0] flags
);
	import gsi_pkg::*;

	genvar i;
	generate
		for (i = 0; i < EVT_CNT; i++) begin : gFlag
			// Set wins over a clear in the same cycle
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					flags[i] <= RST_LATCHED[i];
				end else if (evtSet[i]) begin
					flags[i] <= 1'b1;
				end else if (readClear || swReset) begin
					flags[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> verilog/gsi_serdes_irq_status.sv
// Interrupt enable, latched status and resolved status registers on AXI4-Lite
//
// Function
// - Enable bit 7 gates false-carrier interrupt; resets to zero.
// - Enable bits 14..8 gate the other seven event sources; reset disabled.
// - Latched bit 14 sets on any speed change; read-only, resets zero.
// - Latched bit 13 sets on any duplex change; read-only, resets zero.
// - Page reception sets bit 12 in latched and resolved status registers.
// - Latched bit 11 sets when auto-negotiation completes.
// - Latched bit 10 sets when link goes from up to down.
// - Latched bit 9 sets when link goes from down to up.
// - Latched bit 8 sets on received symbol error, held until cleared.
// - Latched bit 7 sets on false carrier on receive path.
// - Status bits 15:14 give speed: 00 10M, 01 100M, 10 1000M.
// - Speed, duplex and pause fields mean something only while resolved.
// - Resolved bit 11 sets on negotiation done; always one when disabled.
// - Status bit 13: one full duplex, zero half duplex.
// - Status bit 10 shows live unlatched link state.
// - Status bit 5 shows code-group synchronisation.
// - Status bit 4 is one with no receive energy; resets to one.
// - Status bit 3 shows resolved transmit pause.
// - Status bit 2 shows resolved receive pause.
// - Pause bits are informational; no internal behaviour depends on them.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module gsi_serdes_irq_status (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic swReset,
	input gsi_pkg::gsi_pcs_t pcsStatus,
	output logic irqOut,
	input wire logic [gsi_pkg::ADDR_W-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [gsi_pkg::DATA_W-1:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [gsi_pkg::ADDR_W-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [gsi_pkg::DATA_W-1:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready
);
	import gsi_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic awHeld;
	logic [ADDR_W-1:0] awAddr;
	logic wHeld;
	logic [15:0] wData;
	logic [1:0] wStrb;
	logic doWrite;
	logic wrHitEnable;
	logic wrHitLatched;
	logic wrHitResolved;
	logic rdTake;
	logic rdHitEnable;
	logic rdHitLatched;
	logic rdHitResolved;
	logic [15:0] irqEnable;
	logic [EVT_CNT-1:0] evtSet;
	logic [EVT_CNT-1:0] latched;
	logic pageSticky;
	logic resolved;
	gsi_pcs_t pcsNow;
	logic [15:0] latchedWord;
	logic [15:0] resolvedWord;
	gsi_rd_t next_rd;
	logic next_irq;

	// ------------------------------------------------------------
	// Sampling and change detection
	// ------------------------------------------------------------
	gsi_change_detect uDetect (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.swReset(swReset),
		.pcsIn(pcsStatus),
		.pcsNow(pcsNow),
		.evtSet(evtSet)
	);

	// ------------------------------------------------------------
	// Latched event flags
	// ------------------------------------------------------------
	gsi_flag_bank uFlags (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.swReset(swReset),
		.readClear(rdTake && rdHitLatched),
		.evtSet(evtSet),
		.flags(latched)
	);

	// Page flag mirrored in the resolved status register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pageSticky <= 1'b0;
		end else if (evtSet[BIT_PAGE_RCVD-EVT_LSB]) begin
			pageSticky <= 1'b1;
		end else if ((rdTake && rdHitResolved) || swReset) begin
			pageSticky <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Write address and data channels
	// ------------------------------------------------------------
	assign s_axil_awready = !awHeld;
	assign s_axil_wready = !wHeld;
	assign doWrite = awHeld && wHeld && !s_axil_bvalid;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			awHeld <= 1'b0;
			awAddr <= '0;
		end else if (s_axil_awvalid && s_axil_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axil_awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wHeld <= 1'b0;
			wData <= '0;
			wStrb <= '0;
		end else if (s_axil_wvalid && s_axil_wready) begin
			wHeld <= 1'b1;
			wData <= s_axil_wdata[15:0];
			wStrb <= s_axil_wstrb[1:0];
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	always_comb begin
		wrHitEnable = 1'b0;
		wrHitLatched = 1'b0;
		wrHitResolved = 1'b0;
		if (awAddr[ADDR_W-1:2] == ADDR_IRQ_ENABLE[ADDR_W-1:2]) begin
			wrHitEnable = 1'b1;
		end else if (awAddr[ADDR_W-1:2] == ADDR_IRQ_LATCHED[ADDR_W-1:2]) begin
			wrHitLatched = 1'b1;
		end else if (awAddr[ADDR_W-1:2] == ADDR_RESOLVED[ADDR_W-1:2]) begin
			wrHitResolved = 1'b1;
		end
	end

	always_comb begin
		rdHitEnable = 1'b0;
		rdHitLatched = 1'b0;
		rdHitResolved = 1'b0;
		if (s_axil_araddr[ADDR_W-1:2] == ADDR_IRQ_ENABLE[ADDR_W-1:2]) begin
			rdHitEnable = 1'b1;
		end else if (s_axil_araddr[ADDR_W-1:2] == ADDR_IRQ_LATCHED[ADDR_W-1:2]) begin
			rdHitLatched = 1'b1;
		end else if (s_axil_araddr[ADDR_W-1:2] == ADDR_RESOLVED[ADDR_W-1:2]) begin
			rdHitResolved = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Write response
	// ------------------------------------------------------------
	// Read-only registers accept writes and ignore them
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axil_bvalid <= 1'b1;
			if (wrHitEnable || wrHitLatched || wrHitResolved) begin
				s_axil_bresp <= RESP_OKAY;
			end else begin
				s_axil_bresp <= RESP_SLVERR;
			end
		end else if (s_axil_bvalid && s_axil_bready) begin
			s_axil_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupt enable register
	// ------------------------------------------------------------
	// Software reset leaves the enables as they were
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqEnable <= RST_IRQ_ENABLE;
		end else if (doWrite && wrHitEnable) begin
			if (wStrb[0]) begin
				irqEnable[7:0] <= wData[7:0];
			end
			if (wStrb[1]) begin
				irqEnable[15:8] <= wData[15:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Read words
	// ------------------------------------------------------------
	always_comb begin
		latchedWord = '0;
		latchedWord[EVT_LSB +: EVT_CNT] = latched;
	end

	// Forced resolved while negotiation is off
	assign resolved = !pcsNow.anEnabled || pcsNow.anDone;

	// Speed, duplex and pause shown as they are; readers check resolved
	always_comb begin
		resolvedWord = '0;
		resolvedWord[STS_SPEED_MSB:STS_SPEED_LSB] = pcsNow.speed;
		resolvedWord[STS_DUPLEX] = pcsNow.fullDuplex;
		resolvedWord[STS_PAGE] = pageSticky;
		resolvedWord[STS_RESOLVED] = resolved;
		resolvedWord[STS_LINK] = pcsNow.linkUp;
		resolvedWord[STS_SYNC] = pcsNow.syncOk;
		resolvedWord[STS_NO_ENERGY] = pcsNow.noEnergy;
		resolvedWord[STS_TX_PAUSE] = pcsNow.txPause;
		resolvedWord[STS_RX_PAUSE] = pcsNow.rxPause;
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign s_axil_arready = !s_axil_rvalid;
	assign rdTake = s_axil_arvalid && s_axil_arready;

	always_comb begin
		next_rd.data = '0;
		next_rd.resp = RESP_OKAY;
		if (rdHitEnable) begin
			next_rd.data[15:0] = irqEnable;
		end else if (rdHitLatched) begin
			next_rd.data[15:0] = latchedWord;
		end else if (rdHitResolved) begin
			next_rd.data[15:0] = resolvedWord;
		end else begin
			next_rd.resp = RESP_SLVERR;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= '0;
			s_axil_rresp <= RESP_OKAY;
		end else if (rdTake) begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata <= next_rd.data;
			s_axil_rresp <= next_rd.resp;
		end else if (s_axil_rvalid && s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------
	assign next_irq = |(latched & irqEnable[EVT_LSB +: EVT_CNT]);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= next_irq;
		end
	end

endmodule
`default_nettype wire

// >>> bench/gsi_serdes_irq_status_chk.sv
// Concurrent checks on the register bus of the interrupt and status bank
`timescale 1ns/10ps
`default_nettype none
module gsi_serdes_irq_status_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input gsi_pkg::gsi_pcs_t pcsStatus,
	input wire logic s_axil_awvalid,
	input wire logic s_axil_awready,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [gsi_pkg::ADDR_W-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic [gsi_pkg::DATA_W-1:0] s_axil_rdata,
	input wire logic [1:0] s_axil_rresp,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready
);
	import gsi_pkg::*;
	logic arHs;
	logic [17:0] arWord;
	logic isMapped;
	assign arHs = s_axil_arvalid && s_axil_arready;
	assign arWord = s_axil_araddr[19:2];
	assign isMapped = arWord == ADDR_IRQ_ENABLE[19:2] || arWord == ADDR_IRQ_LATCHED[19:2] || arWord == ADDR_RESOLVED[19:2];
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	a_r_hold: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
		else $error("read answer changed before it was taken");
	a_b_hold: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write answer changed before it was taken");
	a_ar_refuse: assert property (s_axil_rvalid |-> !s_axil_arready)
		else $error("read address accepted while answer pending");
	a_r_answer: assert property (arHs |=> s_axil_rvalid)
		else $error("read answer late");
	a_b_answer: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##[1:2] s_axil_bvalid)
		else $error("write answer late");
	a_upper_zero: assert property (s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_unmapped_err: assert property (arHs && !isMapped |=> s_axil_rresp == RESP_SLVERR && s_axil_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	a_mapped_ok: assert property (arHs && isMapped |=> s_axil_rresp == RESP_OKAY)
		else $error("mapped read refused");
	a_latched_resv: assert property (arHs && arWord == ADDR_IRQ_LATCHED[19:2] |=> s_axil_rdata[15] == 1'b0 && s_axil_rdata[6:0] == 7'h00)
		else $error("reserved latched bits not zero");
	a_resolved_forced: assert property (arHs && arWord == ADDR_RESOLVED[19:2] && !pcsStatus.anEnabled && !$past(pcsStatus.anEnabled) |=> s_axil_rdata[11])
		else $error("resolved flag low with negotiation off");
	c_resolved_rd: cover property (arHs && arWord == ADDR_RESOLVED[19:2]);
	c_write_done: cover property (s_axil_bvalid && s_axil_bready);
	c_unmapped_rd: cover property (arHs && !isMapped);
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the interrupt and status bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	import gsi_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, swReset = 1'b0, irqOut;
	gsi_pcs_t pcsStatus;
	logic [19:0] s_axil_awaddr = '0, s_axil_araddr = '0;
	logic [31:0] s_axil_wdata = '0, s_axil_rdata;
	logic [3:0] s_axil_wstrb = '0;
	logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0, s_axil_arvalid = 0, s_axil_rready = 0;
	logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	logic [1:0] s_axil_bresp, s_axil_rresp, wrResp;
	int failures = 0, n_checks = 0;
	gsi_serdes_irq_status dut_u (.clk_sys, .rst_b, .swReset, .pcsStatus, .irqOut, .s_axil_awaddr, .s_axil_awvalid,
		.s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
		.s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
		.s_axil_rvalid, .s_axil_rready);
	always #4 clk_sys = ~clk_sys;
	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, seen, exp);
		end
	endtask
	task tmo(input int n);
		if (n > 50) begin
			failures++;
			$display("CHECK FAILED t=%0t bus wait expired", $time);
			complete_run();
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic [3:0] s);
		logic ta, tw, da, dw;
		int n;
		n = 0;
		da = 0;
		dw = 0;
		@(posedge clk_sys);
		s_axil_awaddr <= a;
		s_axil_wdata <= {16'h0000, d};
		s_axil_wstrb <= s;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ta = !da && s_axil_awready;
			tw = !dw && s_axil_wready;
			@(posedge clk_sys);
			if (ta) s_axil_awvalid <= 1'b0;
			if (tw) s_axil_wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
			tmo(++n);
		end while (!(da && dw));
		do begin
			@(negedge clk_sys);
			ta = s_axil_bvalid;
			wrResp = s_axil_bresp;
			@(posedge clk_sys);
			tmo(++n);
		end while (!ta);
		s_axil_bready <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			t = s_axil_arready;
			@(posedge clk_sys);
			tmo(++n);
		end while (!t);
		s_axil_arvalid <= 1'b0;
		do begin
			@(negedge clk_sys);
			t = s_axil_rvalid;
			d = s_axil_rdata;
			r = s_axil_rresp;
			@(posedge clk_sys);
			tmo(++n);
		end while (!t);
		s_axil_rready <= 1'b0;
	endtask
	task automatic rdc(input logic [19:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk(r, RESP_OKAY);
	endtask
	// Pulse inputs are high for exactly one sampled cycle
	task automatic ev(input int b);
		@(posedge clk_sys);
		case (b)
			7: pcsStatus.falseCarrier <= 1'b1;
			8: pcsStatus.symbolErr <= 1'b1;
			9: pcsStatus.linkUp <= 1'b1;
			10: pcsStatus.linkUp <= 1'b0;
			11: pcsStatus.anDone <= 1'b1;
			12: pcsStatus.pageRcvd <= 1'b1;
			13: pcsStatus.fullDuplex <= !pcsStatus.fullDuplex;
			default: pcsStatus.speed <= SPEED_1000;
		endcase
		@(posedge clk_sys);
		pcsStatus.falseCarrier <= 1'b0;
		pcsStatus.symbolErr <= 1'b0;
		pcsStatus.pageRcvd <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] one;
		logic [1:0] sp;
		pcsStatus = '0;
		pcsStatus.noEnergy = 1'b1;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		rdc(ADDR_IRQ_ENABLE, 32'h00000000);
		rdc(ADDR_IRQ_LATCHED, 32'h00000000);
		rdc(ADDR_RESOLVED, 32'h00000810);
		chk(irqOut, 1'b0);
		wr(ADDR_IRQ_ENABLE, 16'h1234, 4'h1);
		chk(wrResp, RESP_OKAY);
		wr(20'h00100, 16'hFFFF, 4'h3);
		chk(wrResp, RESP_SLVERR);
		rdc(ADDR_IRQ_ENABLE, 32'h00000034);
		wr(ADDR_IRQ_LATCHED, 16'hFFFF, 4'h3);
		rdc(ADDR_IRQ_LATCHED, 32'h00000000);
		rd(20'h00100, d, r);
		chk(d, 32'h00000000);
		chk(r, RESP_SLVERR);
		for (int b = 7; b < 15; b++) begin
			one = 16'h0001 << b;
			wr(ADDR_IRQ_ENABLE, ~one, 4'h3);
			ev(b);
			chk(irqOut, 1'b0);
			if (b == 12) begin
				rd(ADDR_RESOLVED, d, r);
				chk(d[12], 1'b1);
			end
			wr(ADDR_IRQ_ENABLE, 16'hFFFF, 4'h3);
			repeat (3) @(posedge clk_sys);
			chk(irqOut, 1'b1);
			rdc(ADDR_IRQ_LATCHED, {16'h0000, one});
			repeat (3) @(posedge clk_sys);
			chk(irqOut, 1'b0);
			rdc(ADDR_IRQ_LATCHED, 32'h00000000);
		end
		for (int i = 0; i < 4; i++) begin
			sp = (i == 3) ? SPEED_10 : 2'(i);
			@(posedge clk_sys);
			pcsStatus.speed <= sp;
			pcsStatus.fullDuplex <= i[0];
			pcsStatus.linkUp <= !i[0];
			pcsStatus.syncOk <= i[1];
			pcsStatus.noEnergy <= (i == 0);
			pcsStatus.txPause <= i[0];
			pcsStatus.rxPause <= i[1];
			pcsStatus.anEnabled <= (i != 3);
			pcsStatus.anDone <= (i != 1);
			repeat (3) @(posedge clk_sys);
			rdc(ADDR_RESOLVED, {16'h0000, sp, i[0], 1'b0, i != 1, !i[0], 4'h0, i[1], i == 0, i[0], i[1], 2'h0});
		end
		@(posedge clk_sys);
		pcsStatus <= '{noEnergy: 1'b1, speed: 2'h0, default: 1'b0};
		repeat (4) @(posedge clk_sys);
		swReset <= 1'b1;
		@(posedge clk_sys);
		swReset <= 1'b0;
		rdc(ADDR_IRQ_LATCHED, 32'h00000000);
		rdc(ADDR_IRQ_ENABLE, 32'h0000FFFF);
		rdc(ADDR_RESOLVED, 32'h00000810);
		complete_run();
	end
endmodule
bind gsi_serdes_irq_status gsi_serdes_irq_status_chk chk_u (.clk_sys, .rst_b, .pcsStatus, .s_axil_awvalid,
	.s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
	.s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready);
`default_nettype wire
